// *** logic/i2c_master_baud_consts.svh ***
// constants for the two-wire master bit-rate and interrupt control block
`ifndef I2C_MASTER_BAUD_CONSTS_SVH
`define I2C_MASTER_BAUD_CONSTS_SVH

// ==========================================================================
// register indices (byte address is four times the index)
`define IDX_CONTROL_B 6'h04
`define IDX_SCL_PERIOD 6'h0c
`define IDX_IEN_CLEAR 6'h14
`define IDX_IEN_SET 6'h16
`define IDX_IRQ_FLAGS 6'h18

// ==========================================================================
// field positions
`define F_STD_HIGH 7:0
`define F_STD_LOW 15:8
`define F_HS_HIGH 23:16
`define F_HS_LOW 31:24
`define B_SMART 8
`define B_QUICK 9
`define F_CMD 17:16
`define B_ACK_SEL 18
`define B_IRQ_ERR 7
`define B_IRQ_RX 1
`define B_IRQ_TX 0

// ==========================================================================
// reset values, masks and command codes
`define SCL_PERIOD_RESET 32'h0000_0000
`define IRQ_RESET 8'h00
`define IRQ_MASK 8'h83
`define CTRL_MASK 32'h0004_0300
`define CMD_NONE 2'h0
`define CMD_REP_START 2'h1
`define CMD_BYTE_READ 2'h2
`define CMD_STOP 2'h3
`define CNT_ZERO 9'h000
`define CNT_ONE 9'h001

`endif

// *** logic/i2c_master_baud_irq_ctrl.sv ***
// control, scl period timing and interrupt flag logic of a two-wire bus master
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
`include "i2c_master_baud_consts.svh"

module i2c_master_baud_irq_ctrl #(
    parameter int CNT_W = 9
) (
    input wire logic clkSys,
    input wire logic arstN,
    // classic wishbone slave
    input wire logic wbCycI,
    input wire logic wbStbI,
    input wire logic wbWeI,
    input wire logic [7:0] wbAdrI,
    input wire logic [3:0] wbSelI,
    input wire logic [31:0] wbDatI,
    output logic [31:0] wbDatO,
    output logic wbAckO,
    // events from the byte engine, same clock
    input wire logic busActive,
    input wire logic hsMode,
    input wire logic readMode,
    input wire logic rxByteDone,
    input wire logic txByteDone,
    input wire logic addrWrite,
    input wire logic dataWrite,
    input wire logic dataRead,
    input wire logic lengthFault,
    input wire logic targetStretchTimeout,
    input wire logic hostStretchTimeout,
    input wire logic sclLowTimeout,
    input wire logic arbitrationLostFlag,
    input wire logic busFaultFlag,
    // scl pin, open drain
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    // control towards the byte engine
    output logic quickCmdEnable,
    output logic smartModeEnable,
    output logic ackSendStrobe,
    output logic ackValue,
    output logic cmdRepStart,
    output logic cmdByteRead,
    output logic cmdStop,
    output logic clockHold,
    output logic [CNT_W-1:0] condCycles,
    output logic [CNT_W-1:0] busFreeCycles,
    output logic irq
);

    // ======================================================================
    // helpers
    // phase length in cycles of the peripheral clock: field value plus one
    function automatic logic [CNT_W-1:0] plusOne(input logic [7:0] v);
        plusOne = CNT_W'({1'b0, v}) + CNT_W'(`CNT_ONE);
    endfunction

    // register address match for one index
    function automatic logic hitIdx(input logic [7:0] adr, input logic [5:0] idx);
        hitIdx = (adr[7:2] == idx);
    endfunction

    // ======================================================================
    // register state
    logic [31:0] sclPeriod_reg;
    logic [7:0] irqEnable_reg;
    logic [7:0] irqFlags_reg;
    logic quickCmd_reg;
    logic smartMode_reg;
    logic ackSel_reg;
    logic ack_reg;
    logic [31:0] datO_reg;
    logic clkHold_reg;
    logic ackSend_reg;
    logic repStart_reg;
    logic byteRead_reg;
    logic stop_reg;
    logic irq_reg;
    logic [CNT_W-1:0] cond_reg;
    logic [CNT_W-1:0] busFree_reg;
    logic sclMeta_reg;
    logic sclSync_reg;
    i2c_master_baud_pkg::scl_state_t state_reg;
    logic [CNT_W-1:0] cnt_reg;

    // ======================================================================
    // wishbone slave
    logic wbReq;
    logic wbWr;
    logic [31:0] readMux;

    assign wbReq = wbCycI & wbStbI;
    // writes land at the edge where the master sees ack
    assign wbWr = wbReq & wbWeI & ack_reg;

    // one wait state; ack drops in the cycle after it was given
    always_ff @(posedge clkSys or negedge arstN) begin
        if (!arstN) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wbReq & ~ack_reg;
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        readMux = 32'h0000_0000;
        if (hitIdx(wbAdrI, `IDX_SCL_PERIOD)) begin
            readMux = sclPeriod_reg;
        end else if (hitIdx(wbAdrI, `IDX_IEN_CLEAR) || hitIdx(wbAdrI, `IDX_IEN_SET)) begin
            readMux = {24'h00_0000, irqEnable_reg & `IRQ_MASK};
        end else if (hitIdx(wbAdrI, `IDX_IRQ_FLAGS)) begin
            readMux = {24'h00_0000, irqFlags_reg & `IRQ_MASK};
        end else if (hitIdx(wbAdrI, `IDX_CONTROL_B)) begin
            // command bits are strobes and read as zero
            readMux = {13'h0000, ackSel_reg, 2'h0, 6'h00, quickCmd_reg, smartMode_reg, 8'h00};
        end
    end

    // read data sampled at the request, stable while ack is high
    always_ff @(posedge clkSys or negedge arstN) begin
        if (!arstN) begin
            datO_reg <= 32'h0000_0000;
        end else if (wbReq & ~ack_reg) begin
            datO_reg <= readMux;
        end
    end

    assign wbDatO = datO_reg;
    assign wbAckO = ack_reg;

    // ======================================================================
    // scl period configuration, byte lanes honoured
    always_ff @(posedge clkSys or negedge arstN) begin
        if (!arstN) begin
            sclPeriod_reg <= `SCL_PERIOD_RESET;
        end else if (wbWr && hitIdx(wbAdrI, `IDX_SCL_PERIOD)) begin
            for (int b = 0; b < 4; b++) begin
                if (wbSelI[b]) begin
                    sclPeriod_reg[b*8 +: 8] <= wbDatI[b*8 +: 8];
                end
            end
        end
    end

    // ======================================================================
    // control b: quick command, smart mode, acknowledge select
    logic ctrlWr;
    logic [1:0] cmdWr;
    logic cmdValid;
    logic releaseAct;

    assign ctrlWr = wbWr & hitIdx(wbAdrI, `IDX_CONTROL_B);
    assign cmdWr = (ctrlWr & wbSelI[2]) ? wbDatI[`F_CMD] : `CMD_NONE;
    // byte read in write mode is no operation; commands need a pending hold
    assign cmdValid = (cmdWr != `CMD_NONE) && clkHold_reg && !((cmdWr == `CMD_BYTE_READ) && !readMode);
    // actions that resume the stalled transfer
    assign releaseAct = addrWrite | dataWrite | (dataRead & smartMode_reg) | cmdValid;

    always_ff @(posedge clkSys or negedge arstN) begin
        if (!arstN) begin
            quickCmd_reg <= 1'b0;
            smartMode_reg <= 1'b0;
        end else if (ctrlWr && wbSelI[1]) begin
            quickCmd_reg <= wbDatI[`B_QUICK];
            smartMode_reg <= wbDatI[`B_SMART];
        end
    end

    // written together with a command, the new select is used by it
    always_ff @(posedge clkSys or negedge arstN) begin
        if (!arstN) begin
            ackSel_reg <= 1'b0;
        end else if (ctrlWr && wbSelI[2]) begin
            ackSel_reg <= wbDatI[`B_ACK_SEL];
        end
    end

    // acknowledge action and command strobes, one cycle pulses
    always_ff @(posedge clkSys or negedge arstN) begin
        if (!arstN) begin
            ackSend_reg <= 1'b0;
            repStart_reg <= 1'b0;
            byteRead_reg <= 1'b0;
            stop_reg <= 1'b0;
        end else begin
            ackSend_reg <= cmdValid | (dataRead & smartMode_reg);
            repStart_reg <= cmdValid && (cmdWr == `CMD_REP_START);
            byteRead_reg <= cmdValid && (cmdWr == `CMD_BYTE_READ);
            stop_reg <= cmdValid && (cmdWr == `CMD_STOP);
        end
    end

    assign quickCmdEnable = quickCmd_reg;
    assign smartModeEnable = smartMode_reg;
    assign ackSendStrobe = ackSend_reg;
    assign ackValue = ackSel_reg;
    assign cmdRepStart = repStart_reg;
    assign cmdByteRead = byteRead_reg;
    assign cmdStop = stop_reg;

    // ======================================================================
    // interrupt enables: set and clear views of one register
    always_ff @(posedge clkSys or negedge arstN) begin
        if (!arstN) begin
            irqEnable_reg <= `IRQ_RESET;
        end else if (wbWr && wbSelI[0] && hitIdx(wbAdrI, `IDX_IEN_CLEAR)) begin
            irqEnable_reg <= irqEnable_reg & ~(wbDatI[7:0] & `IRQ_MASK);
        end else if (wbWr && wbSelI[0] && hitIdx(wbAdrI, `IDX_IEN_SET)) begin
            irqEnable_reg <= irqEnable_reg | (wbDatI[7:0] & `IRQ_MASK);
        end
    end

    // ======================================================================
    // interrupt flags; a hardware set wins over a clear in the same cycle
    logic flagWr;
    logic [7:0] flagSet;
    logic [7:0] flagClr;
    logic anyError;
    logic rxSet;
    logic txSet;

    assign flagWr = wbWr & wbSelI[0] & hitIdx(wbAdrI, `IDX_IRQ_FLAGS);
    assign anyError = lengthFault | targetStretchTimeout | hostStretchTimeout
                    | sclLowTimeout | arbitrationLostFlag | busFaultFlag;
    assign rxSet = rxByteDone & ~arbitrationLostFlag & ~busFaultFlag;
    assign txSet = txByteDone;

    always_comb begin
        flagSet = 8'h00;
        flagSet[`B_IRQ_ERR] = anyError;
        flagSet[`B_IRQ_RX] = rxSet;
        flagSet[`B_IRQ_TX] = txSet;
        flagClr = flagWr ? (wbDatI[7:0] & `IRQ_MASK) : 8'h00;
        flagClr[`B_IRQ_RX] = flagClr[`B_IRQ_RX] | releaseAct;
        flagClr[`B_IRQ_TX] = flagClr[`B_IRQ_TX] | releaseAct;
    end

    always_ff @(posedge clkSys or negedge arstN) begin
        if (!arstN) begin
            irqFlags_reg <= `IRQ_RESET;
        end else begin
            irqFlags_reg <= ((irqFlags_reg & ~flagClr) | flagSet) & `IRQ_MASK;
        end
    end

    // interrupt request, registered
    always_ff @(posedge clkSys or negedge arstN) begin
        if (!arstN) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irqFlags_reg & irqEnable_reg);
        end
    end

    assign irq = irq_reg;

    // ======================================================================
    // clock hold: kept apart from the flags so a flag clear does not resume
    always_ff @(posedge clkSys or negedge arstN) begin
        if (!arstN) begin
            clkHold_reg <= 1'b0;
        end else if (rxSet || (txSet && !arbitrationLostFlag)) begin
            clkHold_reg <= 1'b1;
        end else if (releaseAct) begin
            clkHold_reg <= 1'b0;
        end
    end

    assign clockHold = clkHold_reg;

    // ======================================================================
    // scl input synchroniser
    always_ff @(posedge clkSys or negedge arstN) begin
        if (!arstN) begin
            sclMeta_reg <= 1'b1;
            sclSync_reg <= 1'b1;
        end else begin
            sclMeta_reg <= sclIn;
            sclSync_reg <= sclMeta_reg;
        end
    end

    // ======================================================================
    // phase lengths
    logic [7:0] stdHigh;
    logic [7:0] stdLow;
    logic [7:0] hsHigh;
    logic [7:0] hsLow;
    logic [CNT_W-1:0] lowCycles;
    logic [CNT_W-1:0] highCycles;

    assign stdHigh = sclPeriod_reg[`F_STD_HIGH];
    assign stdLow = sclPeriod_reg[`F_STD_LOW];
    assign hsHigh = sclPeriod_reg[`F_HS_HIGH];
    assign hsLow = sclPeriod_reg[`F_HS_LOW];

    always_comb begin
        if (hsMode) begin
            lowCycles = (hsLow != 8'h00) ? plusOne(hsLow) : plusOne(hsHigh);
            highCycles = plusOne(hsHigh);
        end else begin
            lowCycles = (stdLow != 8'h00) ? plusOne(stdLow) : plusOne(stdHigh);
            highCycles = plusOne(stdHigh);
        end
    end

    // start/stop setup and hold from the high field; bus free always standard
    always_ff @(posedge clkSys or negedge arstN) begin
        if (!arstN) begin
            cond_reg <= CNT_W'(`CNT_ONE);
            busFree_reg <= CNT_W'(`CNT_ONE);
        end else begin
            cond_reg <= hsMode ? plusOne(hsHigh) : highCycles;
            busFree_reg <= plusOne(stdHigh);
        end
    end

    assign condCycles = cond_reg;
    assign busFreeCycles = busFree_reg;

    // ======================================================================
    // scl phase generator; high phase waits while a slave stretches the clock
    always_ff @(posedge clkSys or negedge arstN) begin
        if (!arstN) begin
            state_reg <= i2c_master_baud_pkg::SCL_IDLE;
            cnt_reg <= CNT_W'(`CNT_ZERO);
        end else begin
            case (state_reg)
                i2c_master_baud_pkg::SCL_IDLE: begin
                    if (busActive) begin
                        state_reg <= i2c_master_baud_pkg::SCL_LOW;
                        cnt_reg <= lowCycles - CNT_W'(`CNT_ONE);
                    end
                end
                i2c_master_baud_pkg::SCL_LOW: begin
                    if (clkHold_reg) begin
                        cnt_reg <= cnt_reg;
                    end else if (cnt_reg == CNT_W'(`CNT_ZERO)) begin
                        state_reg <= i2c_master_baud_pkg::SCL_HIGH;
                        cnt_reg <= highCycles - CNT_W'(`CNT_ONE);
                    end else begin
                        cnt_reg <= cnt_reg - CNT_W'(`CNT_ONE);
                    end
                end
                i2c_master_baud_pkg::SCL_HIGH: begin
                    if (!sclSync_reg) begin
                        cnt_reg <= cnt_reg;
                    end else if (cnt_reg != CNT_W'(`CNT_ZERO)) begin
                        cnt_reg <= cnt_reg - CNT_W'(`CNT_ONE);
                    end else if (busActive) begin
                        state_reg <= i2c_master_baud_pkg::SCL_LOW;
                        cnt_reg <= lowCycles - CNT_W'(`CNT_ONE);
                    end else begin
                        state_reg <= i2c_master_baud_pkg::SCL_IDLE;
                    end
                end
                default: begin
                    state_reg <= i2c_master_baud_pkg::SCL_IDLE;
                    cnt_reg <= CNT_W'(`CNT_ZERO);
                end
            endcase
        end
    end

    // open drain: only ever pulls low
    assign sclOut = 1'b0;
    assign sclOe = (state_reg == i2c_master_baud_pkg::SCL_LOW);

    // ======================================================================
    // assertions
    default clocking cb @(posedge clkSys); endclocking
    default disable iff (!arstN);

    logic enterLow;
    logic enterHigh;
    assign enterLow = (state_reg != i2c_master_baud_pkg::SCL_LOW) && busActive
                    && !((state_reg == i2c_master_baud_pkg::SCL_HIGH) && (!sclSync_reg || cnt_reg != 0));

    AST_QUICK_CMD: assert property (ctrlWr && wbSelI[1] |=> quickCmdEnable == $past(wbDatI[`B_QUICK]))
        else $error("quick command enable did not follow write");
    AST_SMART_ACK: assert property (dataRead && smartModeEnable |=> ackSendStrobe ##1 !ackSendStrobe[*1])
        else $error("smart read gave no acknowledge pulse");
    AST_HS_LOW: assert property (enterLow && hsMode && hsLow != 0 |=> cnt_reg == $past(CNT_W'({1'b0, hsLow})))
        else $error("hs low phase length wrong");
    AST_HS_LOW_ZERO: assert property (enterLow && hsMode && hsLow == 0 |=> cnt_reg == $past(CNT_W'({1'b0, hsHigh})))
        else $error("hs low phase not timed from hs high field");
    AST_HS_HIGH: assert property (state_reg == i2c_master_baud_pkg::SCL_LOW && !clkHold_reg && cnt_reg == 0 && hsMode
        |=> state_reg == i2c_master_baud_pkg::SCL_HIGH && cnt_reg == $past(CNT_W'({1'b0, hsHigh})))
        else $error("hs high phase length wrong");
    AST_STD_LOW: assert property (enterLow && !hsMode && stdLow != 0 |=> cnt_reg == $past(CNT_W'({1'b0, stdLow})))
        else $error("standard low phase length wrong");
    AST_STD_BOTH: assert property (enterLow && !hsMode && stdLow == 0 |=> cnt_reg == $past(CNT_W'({1'b0, stdHigh})))
        else $error("standard low phase not timed from high field");
    AST_IEN_CLR: assert property (wbWr && wbSelI[0] && hitIdx(wbAdrI, `IDX_IEN_CLEAR)
        |=> (irqEnable_reg & $past(wbDatI[7:0])) == 8'h00)
        else $error("enable clear left a bit set");
    AST_IEN_SET: assert property (wbWr && wbSelI[0] && hitIdx(wbAdrI, `IDX_IEN_SET)
        |=> (irqEnable_reg & $past(wbDatI[7:0]) & `IRQ_MASK) == ($past(wbDatI[7:0]) & `IRQ_MASK))
        else $error("enable set missed a bit");
    AST_IEN_RSVD: assert property ((irqEnable_reg & ~`IRQ_MASK) == 8'h00)
        else $error("reserved enable bit set");
    AST_ERR_SET: assert property (anyError |=> irqFlags_reg[`B_IRQ_ERR])
        else $error("error condition did not set error flag");
    AST_ERR_W1C: assert property (flagWr && wbDatI[`B_IRQ_ERR] && !anyError |=> !irqFlags_reg[`B_IRQ_ERR])
        else $error("write one did not clear error flag");
    AST_RX_SET: assert property (rxSet |=> irqFlags_reg[`B_IRQ_RX] && clkHold_reg)
        else $error("received byte did not set rx flag");
    AST_HOLD_LOW: assert property (clkHold_reg && sclOe |=> sclOe)
        else $error("scl released while hold pending");
    AST_RELEASE: assert property (releaseAct && !rxSet && !txSet |=> !clkHold_reg && !irqFlags_reg[`B_IRQ_RX])
        else $error("release action did not resume bus");
    AST_FLAG_ONLY: assert property (clkHold_reg && flagWr && wbDatI[`B_IRQ_RX] && !releaseAct |=> clkHold_reg)
        else $error("flag clear resumed the bus");
    AST_CMD_STOP: assert property (cmdValid && cmdWr == `CMD_STOP |=> cmdStop && ackSendStrobe && !cmdRepStart)
        else $error("stop command not decoded");
    AST_CMD_READ_WR: assert property (ctrlWr && wbSelI[2] && wbDatI[`F_CMD] == `CMD_BYTE_READ && !readMode
        |=> !cmdByteRead && !ackSendStrobe)
        else $error("byte read issued in write mode");
    AST_TX_SET: assert property (txByteDone && !arbitrationLostFlag |=> irqFlags_reg[`B_IRQ_TX] && clkHold_reg)
        else $error("sent byte did not set tx flag and hold");
    AST_IRQ: assert property ((irqFlags_reg & irqEnable_reg) != 8'h00 |=> irq)
        else $error("interrupt not raised");

    COV_RX_RELEASE: cover property (rxSet ##[1:50] releaseAct);
    COV_HS_LOW: cover property (enterLow && hsMode && hsLow != 0);
    COV_ERR_IRQ: cover property (anyError ##1 irqEnable_reg[`B_IRQ_ERR] ##1 irq);
    COV_STRETCH: cover property (state_reg == i2c_master_baud_pkg::SCL_HIGH && !sclSync_reg);

endmodule

// *** logic/i2c_master_baud_pkg.sv ***
// types shared by the two-wire master bit-rate and interrupt control block
package i2c_master_baud_pkg;
    typedef enum logic [1:0] {SCL_IDLE, SCL_LOW, SCL_HIGH} scl_state_t;
endpackage

// *** verif/i2c_bus_target.sv ***
// behavioural target device on the open-drain scl line
`timescale 1ns/1ns
module i2c_bus_target (
    input wire logic clk,
    input wire logic slow,
    input wire logic sclOe,
    output logic sclIn
);
    // starts released so the line shows its pull-up level before the first low phase
    logic [2:0] holdCnt = 3'h0;
    // a slow target keeps scl low a few cycles after the master lets go
    always @(posedge clk) begin
        holdCnt <= sclOe ? (slow ? 3'h5 : 3'h0) : (holdCnt != 3'h0 ? holdCnt - 3'h1 : 3'h0);
    end
    // pull-up: the line is high only when nobody pulls it low
    assign sclIn = !(sclOe || holdCnt != 3'h0);
endmodule

// *** verif/i2c_master_baud_irq_ctrl_tb.sv ***
// self-checking bench for the two-wire master bit-rate and interrupt block
`timescale 1ns/1ns
module i2c_master_baud_irq_ctrl_tb;
    logic clk, rstN, cyc, stb, we, busAct, hs, rdM, slow, clrSeen;
    logic [7:0] adr, sh, sl, hh, hl, ien;
    logic [31:0] dat, q, w, datO;
    logic [10:0] ev;
    logic [3:0] seen;
    logic [8:0] bfc, cnd;
    logic ack, sclIn, sclOe, qce, sme, ackStb, ackVal, rep, brd, stp, hold, irq;
    int num_errors, n_checks, cycles, i, n, e;
    // ==========
    // device and target
    i2c_master_baud_irq_ctrl i2c_master_baud_irq_ctrl_i (
        .clkSys(clk), .arstN(rstN), .wbCycI(cyc), .wbStbI(stb), .wbWeI(we), .wbAdrI(adr), .wbSelI(4'hf),
        .wbDatI(dat), .wbDatO(datO), .wbAckO(ack), .busActive(busAct), .hsMode(hs), .readMode(rdM),
        .rxByteDone(ev[0]), .txByteDone(ev[1]), .addrWrite(ev[2]), .dataWrite(ev[3]), .dataRead(ev[4]),
        .lengthFault(ev[5]), .targetStretchTimeout(ev[6]), .hostStretchTimeout(ev[7]),
        .sclLowTimeout(ev[8]), .arbitrationLostFlag(ev[9]), .busFaultFlag(ev[10]), .sclIn(sclIn),
        .sclOut(), .sclOe(sclOe), .quickCmdEnable(qce), .smartModeEnable(sme), .ackSendStrobe(ackStb),
        .ackValue(ackVal), .cmdRepStart(rep), .cmdByteRead(brd), .cmdStop(stp), .clockHold(hold),
        .condCycles(cnd), .busFreeCycles(bfc), .irq(irq));
    i2c_bus_target i2c_bus_target_i (.clk(clk), .slow(slow), .sclOe(sclOe), .sclIn(sclIn));
    // ==========
    // clock, strobe capture and watchdog
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // strobes last one cycle, so they are caught in a sticky word
    always @(posedge clk) begin
        seen <= clrSeen ? 4'h0 : seen | {stp, brd, rep, ackStb};
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            end_sim();
        end
    end
    // ==========
    // tasks
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // classic cycle; ack is sampled on the edge itself, before it updates; only the watchdog ends a wait
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        {cyc, stb, we, adr, dat} <= {2'b11, wr, a, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = datO;
        {cyc, stb, we} <= 3'b000;
        @(posedge clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        wb(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    task automatic pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // counts cycles of the next low phase driven by the master
    task automatic lowlen(output int c);
        int t;
        t = 0;
        c = 0;
        while (sclOe !== 1'b1 && t < 3000) begin
            @(posedge clk);
            t++;
        end
        while (sclOe === 1'b1 && t < 3000) begin
            @(posedge clk);
            c++;
            t++;
        end
    endtask
    // ==========
    // sequence
    initial begin
        {cyc, stb, we, adr, dat, busAct, hs, rdM, slow, ev, clrSeen} = '0;
        rstN = 0;
        void'($urandom(56981));
        repeat (4) @(posedge clk);
        rstN <= 1;
        @(posedge clk);
        rc(8'h58, 0);
        rc(8'h30, 0);
        ien = 0;
        for (i = 0; i < 8; i++) begin
            w = $urandom;
            wb(1, i[0] ? 8'h50 : 8'h58, w);
            ien = i[0] ? ien & ~w[7:0] : ien | (w[7:0] & 8'h83);
            rc(8'h50, {24'h0, ien});
            rc(8'h58, {24'h0, ien});
        end
        wb(1, 8'hfc, 32'hffff_ffff);
        rc(8'hfc, 0);
        $display("register test done");
        for (i = 0; i < 4; i++) begin
            sh = 8'($urandom_range(20, 1));
            hh = 8'($urandom_range(20, 1));
            sl = i[0] ? 8'h00 : 8'($urandom_range(20, 1));
            hl = i[0] ? 8'h00 : 8'($urandom_range(20, 1));
            w = {hl, hh, sl, sh};
            wb(1, 8'h30, w);
            rc(8'h30, w);
            chk(bfc, sh + 1);
            {hs, slow, busAct} <= {i[1], i[0], 1'b1};
            lowlen(n);
            lowlen(n);
            e = i[1] ? (hl != 0 ? hl : hh) : (sl != 0 ? sl : sh);
            chk(n, e + 1);
            chk(cnd, (i[1] ? hh : sh) + 1);
            busAct <= 0;
            repeat (60) @(posedge clk);
        end
        $display("timing test done");
        wb(1, 8'h58, 32'h83);
        for (i = 5; i < 11; i++) begin
            pulse(i);
            rc(8'h60, 32'h80);
            chk(irq, 1);
            wb(1, 8'h60, 32'h7f);
            rc(8'h60, 32'h80);
            wb(1, 8'h60, 32'h80);
            rc(8'h60, 0);
            chk(irq, 0);
        end
        $display("error flag test done");
        for (i = 0; i < 6; i++) begin
            w = {13'h0, 1'($urandom), 2'(i > 2 ? i - 2 : 0), 6'h0, 1'($urandom), 9'h100};
            rdM <= !i[0];
            busAct <= (i == 0);
            pulse(i[0]);
            chk(hold, 1);
            rc(8'h60, i[0] ? 1 : 2);
            wb(1, 8'h60, i[0] ? 1 : 2);
            rc(8'h60, 0);
            chk(hold, 1);
            // with scl running, a pending hold must keep the line low long past any phase length
            if (i == 0) begin
                repeat (30) @(posedge clk);
                chk(sclOe, 1);
            end
            if (i == 2) wb(1, 8'h10, w);
            clrSeen <= 1;
            @(posedge clk);
            clrSeen <= 0;
            if (i < 2) pulse(i + 2);
            else if (i == 2) pulse(4);
            else wb(1, 8'h10, w);
            repeat (2) @(posedge clk);
            chk(hold, 0);
            if (i >= 2) begin
                chk(seen, i < 3 ? 4'h1 : 4'h1 | (4'h1 << (i - 2)));
                chk(ackVal, w[18]);
                chk({qce, sme}, {w[9], 1'b1});
                rc(8'h10, w & 32'h0004_0300);
            end
        end
        // byte read in write mode is refused and keeps the hold
        rdM <= 0;
        pulse(1);
        clrSeen <= 1;
        @(posedge clk);
        clrSeen <= 0;
        wb(1, 8'h10, 32'h0002_0100);
        repeat (2) @(posedge clk);
        chk(seen, 0);
        chk(hold, 1);
        pulse(2);
        clrSeen <= 1;
        @(posedge clk);
        clrSeen <= 0;
        wb(1, 8'h10, 32'h0003_0100);
        repeat (2) @(posedge clk);
        chk(seen, 0);
        $display("hold test done");
        end_sim();
    end
endmodule
